// File: design/gtf_pkg.sv
// Package: register map, field layouts, codes and timing constants for the trigger and filter config block
package gtf_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GPIO1_CONFIG = 8'h05;
  localparam logic [7:0] ADDR_PIN_CONV_CONFIG = 8'h06;
  localparam logic [7:0] ADDR_PIN_SEQ_START = 8'h07;
  localparam logic [7:0] ADDR_FILTER_CONFIG = 8'h08;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_GPIO1_CONFIG = 8'h00;
  localparam logic [7:0] RST_PIN_CONV_CONFIG = 8'h00;
  localparam logic [7:0] RST_PIN_SEQ_START = 8'h3A;
  localparam logic [7:0] RST_FILTER_CONFIG = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] DIR_INPUT = 2'h0;
  localparam logic [1:0] DIR_RESERVED = 2'h1;
  localparam logic [1:0] DIR_OPEN_DRAIN = 2'h2;
  localparam logic [1:0] DIR_PUSH_PULL = 2'h3;

  localparam logic [1:0] ISEL_OFF = 2'h0;
  localparam logic [1:0] ISEL_CONV_START = 2'h1;
  localparam logic [1:0] ISEL_SEQ_START = 2'h2;
  localparam logic [1:0] ISEL_RESERVED = 2'h3;

  localparam logic [2:0] OSEL_HIGH_Z = 3'h0;
  localparam logic [2:0] OSEL_INT_LOW = 3'h1;
  localparam logic [2:0] OSEL_INT_HIGH = 3'h2;
  localparam logic [2:0] OSEL_LOGIC0 = 3'h3;
  localparam logic [2:0] OSEL_LOGIC1 = 3'h4;
  localparam logic [2:0] OSEL_LOW_SWITCH = 3'h5;
  localparam logic [2:0] OSEL_MOD_ACTIVE = 3'h6;
  localparam logic [2:0] OSEL_SYS_CLOCK = 3'h7;

  localparam logic [1:0] CTYPE_SINGLE = 2'h0;
  localparam logic [1:0] CTYPE_CONTINUOUS = 2'h1;
  localparam logic [1:0] CTYPE_DUTY_A = 2'h2;
  localparam logic [1:0] CTYPE_DUTY_B = 2'h3;

  localparam logic [1:0] FTYPE_50_60HZ = 2'h0;
  localparam logic [1:0] FTYPE_50HZ = 2'h1;
  localparam logic [1:0] FTYPE_60HZ = 2'h2;
  localparam logic [1:0] FTYPE_SINC4 = 2'h3;

  // Power state as seen from the power controller
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h1;
  localparam logic [1:0] PWR_SLEEP = 2'h2;

  // Sequencer start pointer window
  localparam logic [6:0] SEQ_ADDR_MIN = 7'h3A;
  localparam logic [6:0] SEQ_ADDR_MAX = 7'h6F;

  // ----------------------------------------------------------------
  // Timing: system clock output from a phase accumulator
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int SYSCLK_OUT_KHZ = 2456;
  localparam int PHASE_W = 16;
  localparam logic [15:0] PHASE_INC = 16'((SYSCLK_OUT_KHZ * (1 << PHASE_W)) / CLK_FREQ_KHZ);

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] dir;
    logic [1:0] isel;
    logic rsv3;
    logic [2:0] osel;
  } gtf_gpio_cfg_t;

  typedef struct packed {
    logic rsv7;
    logic [2:0] dest;
    logic [1:0] rsv32;
    logic [1:0] ctype;
  } gtf_conv_cfg_t;

  typedef struct packed {
    logic rsv7;
    logic [6:0] addr;
  } gtf_seq_cfg_t;

  typedef struct packed {
    logic rsv7;
    logic rsv6;
    logic [1:0] ftype;
    logic [3:0] rate;
  } gtf_filter_cfg_t;

  typedef struct packed {
    logic [1:0] ctype;
    logic [2:0] dest;
  } gtf_conv_req_t;

  typedef struct packed {
    logic [1:0] ftype;
    logic [3:0] rate;
  } gtf_filter_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAKE,
    ST_LAUNCH
  } gtf_trig_state_t;

endpackage : gtf_pkg

// File: design/gtf_edge_sync.sv
// Two-flop synchroniser with registered rising-edge detect for the trigger pin
`timescale 1ns/100ps
`default_nettype none

module gtf_edge_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic rise
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ----------------------------------------------------------------
  // Synchroniser; meta_r feeds sync_r only
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edge compares two settled samples, so a pulse needs one clock of each level
  // sampled edge compare
  always_ff @(posedge clk) begin
    if (rst) begin
      rise <= 1'b0;
    end else begin
      rise <= sync_r & ~prev_r;
    end
  end

endmodule : gtf_edge_sync
`default_nettype wire

// File: design/gtf_pin_drive.sv
// Output function and drive-type selection for the second general-purpose pin
`timescale 1ns/100ps
`default_nettype none

module gtf_pin_drive (
  input wire logic clk,
  input wire logic rst,
  input wire gtf_pkg::gtf_gpio_cfg_t cfg,
  input wire logic irq,
  input wire logic mod_active,
  input wire logic lsw_close,
  output logic pin_o,
  output logic pin_oe
);

  logic [15:0] phase_r;
  logic level;
  logic drive;
  logic od_force;

  // ----------------------------------------------------------------
  // Nominal system clock; PHASE_INC truncates, so the average rate sits just below SYSCLK_OUT_KHZ, edges jitter by one CLK
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= 16'h0000;
    end else begin
      phase_r <= phase_r + gtf_pkg::PHASE_INC;
    end
  end

  // Level and whether the function wants the pin driven at all
  // output function select
  always_comb begin
    level = 1'b0;
    drive = 1'b1;
    od_force = 1'b0;
    case (cfg.osel)
      gtf_pkg::OSEL_HIGH_Z: drive = 1'b0;
      gtf_pkg::OSEL_INT_LOW: level = ~irq;
      gtf_pkg::OSEL_INT_HIGH: level = irq;
      gtf_pkg::OSEL_LOGIC0: level = 1'b0;
      gtf_pkg::OSEL_LOGIC1: level = 1'b1;
      gtf_pkg::OSEL_LOW_SWITCH: begin
        level = ~lsw_close;
        od_force = 1'b1;
      end
      gtf_pkg::OSEL_MOD_ACTIVE: level = mod_active;
      gtf_pkg::OSEL_SYS_CLOCK: level = phase_r[15];
      default: drive = 1'b0;
    endcase
  end

  // Drive type; the switch only ever sinks, even in push-pull mode
  // direction and drive type
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else if (!drive || cfg.dir == gtf_pkg::DIR_INPUT) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else if (cfg.dir == gtf_pkg::DIR_PUSH_PULL && !od_force) begin
      pin_o <= level;
      pin_oe <= 1'b1;
    end else begin
      pin_o <= 1'b0;
      pin_oe <= ~level;
    end
  end

endmodule : gtf_pin_drive
`default_nettype wire

// File: design/gtf_trigger_cfg.sv
// Top: pin trigger, pin conversion/sequence setup and filter configuration registers
`timescale 1ns/100ps
`default_nettype none

module gtf_trigger_cfg (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic PIN_I,
  output logic PIN_O,
  output logic PIN_OE,
  input wire logic [1:0] POWER_STATE,
  output logic WAKE_REQ,
  input wire logic INTERRUPT_ACTIVE_HIGH_LEVEL,
  input wire logic MOD_ACTIVE,
  input wire logic LSW_CLOSE,
  output logic CONV_START,
  output gtf_pkg::gtf_conv_req_t CONV_REQ,
  output logic SEQ_START,
  output logic [6:0] SEQ_ADDR,
  output gtf_pkg::gtf_filter_sel_t FILTER_SEL,
  input wire logic CAL_START,
  output gtf_pkg::gtf_filter_sel_t CAL_FILTER_SEL
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Write strobe aimed at one register
  function automatic logic wr_hit(
    input logic wr,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    wr_hit = wr && (addr == target);
  endfunction : wr_hit

  // Pointer inside the sequencer microcode window
  function automatic logic seq_ok(input logic [6:0] addr);
    seq_ok = (addr >= gtf_pkg::SEQ_ADDR_MIN) && (addr <= gtf_pkg::SEQ_ADDR_MAX);
  endfunction : seq_ok

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  gtf_pkg::gtf_gpio_cfg_t gpio_r;
  gtf_pkg::gtf_conv_cfg_t conv_r;
  gtf_pkg::gtf_seq_cfg_t seq_r;
  gtf_pkg::gtf_filter_cfg_t filt_r;
  gtf_pkg::gtf_gpio_cfg_t gpio_wr;
  gtf_pkg::gtf_conv_cfg_t conv_wr;
  gtf_pkg::gtf_seq_cfg_t seq_wr;
  gtf_pkg::gtf_filter_cfg_t filt_wr;
  gtf_pkg::gtf_trig_state_t state_r;
  gtf_pkg::gtf_trig_state_t state_nxt;
  logic pend_seq_r;
  logic pin_rise;
  logic trig_en;
  logic trig_seq;
  logic awake;
  logic fire;
  logic fire_seq;
  logic [7:0] rdata_nxt;

  assign gpio_wr = gtf_pkg::gtf_gpio_cfg_t'(REG_WDATA);
  assign conv_wr = gtf_pkg::gtf_conv_cfg_t'(REG_WDATA);
  assign seq_wr = gtf_pkg::gtf_seq_cfg_t'(REG_WDATA);
  assign filt_wr = gtf_pkg::gtf_filter_cfg_t'(REG_WDATA);

  // ----------------------------------------------------------------
  // Pin control register
  // ----------------------------------------------------------------

  // Dir and isel each filter their own reserved code, so a mixed write still
  // updates the legal fields. Bit 3 is not stored.
  // drop reserved codes
  always_ff @(posedge CLK) begin
    if (RST) begin
      gpio_r <= gtf_pkg::gtf_gpio_cfg_t'(gtf_pkg::RST_GPIO1_CONFIG);
    end else if (wr_hit(REG_WR, REG_ADDR, gtf_pkg::ADDR_GPIO1_CONFIG)) begin
      if (gpio_wr.dir != gtf_pkg::DIR_RESERVED) begin
        gpio_r.dir <= gpio_wr.dir;
      end
      if (gpio_wr.isel != gtf_pkg::ISEL_RESERVED) begin
        gpio_r.isel <= gpio_wr.isel;
      end
      gpio_r.osel <= gpio_wr.osel;
    end
  end

  // ----------------------------------------------------------------
  // Pin conversion setup register
  // ----------------------------------------------------------------

  // Storage only; a write never starts a conversion, the fields are sampled at launch
  // store without starting
  always_ff @(posedge CLK) begin
    if (RST) begin
      conv_r <= gtf_pkg::gtf_conv_cfg_t'(gtf_pkg::RST_PIN_CONV_CONFIG);
    end else if (wr_hit(REG_WR, REG_ADDR, gtf_pkg::ADDR_PIN_CONV_CONFIG)) begin
      conv_r.dest <= conv_wr.dest;
      conv_r.ctype <= conv_wr.ctype;
    end
  end

  // ----------------------------------------------------------------
  // Sequence start pointer register
  // ----------------------------------------------------------------

  // Out-of-window writes are dropped so the sequencer never jumps
  // into the register file below the microcode area
  // pointer window check
  always_ff @(posedge CLK) begin
    if (RST) begin
      seq_r <= gtf_pkg::gtf_seq_cfg_t'(gtf_pkg::RST_PIN_SEQ_START);
    end else if (wr_hit(REG_WR, REG_ADDR, gtf_pkg::ADDR_PIN_SEQ_START) && seq_ok(seq_wr.addr)) begin
      seq_r.addr <= seq_wr.addr;
    end
  end

  // ----------------------------------------------------------------
  // Filter configuration register
  // ----------------------------------------------------------------

  // Bit 6 is stored as written and steers nothing; software keeps it 0
  // reserved bit kept
  always_ff @(posedge CLK) begin
    if (RST) begin
      filt_r <= gtf_pkg::gtf_filter_cfg_t'(gtf_pkg::RST_FILTER_CONFIG);
    end else if (wr_hit(REG_WR, REG_ADDR, gtf_pkg::ADDR_FILTER_CONFIG)) begin
      filt_r.rsv6 <= filt_wr.rsv6;
      filt_r.ftype <= filt_wr.ftype;
      filt_r.rate <= filt_wr.rate;
    end
  end

  // Rate is passed with its filter type; the decimator decodes the pair
  // rate paired with type
  always_ff @(posedge CLK) begin
    if (RST) begin
      FILTER_SEL <= '0;
    end else begin
      FILTER_SEL.ftype <= filt_r.ftype;
      FILTER_SEL.rate <= filt_r.rate;
    end
  end

  // Snapshot at start; later writes do not disturb a running calibration
  // calibration snapshot
  always_ff @(posedge CLK) begin
    if (RST) begin
      CAL_FILTER_SEL <= '0;
    end else if (CAL_START) begin
      CAL_FILTER_SEL.ftype <= filt_r.ftype;
      CAL_FILTER_SEL.rate <= filt_r.rate;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------

  // Unstored bits read as zero; unmapped offsets read zero
  always_comb begin
    rdata_nxt = gtf_pkg::READ_UNMAPPED;
    case (REG_ADDR)
      gtf_pkg::ADDR_GPIO1_CONFIG: begin
        rdata_nxt = {gpio_r.dir, gpio_r.isel, 1'b0, gpio_r.osel};
      end
      gtf_pkg::ADDR_PIN_CONV_CONFIG: begin
        rdata_nxt = {1'b0, conv_r.dest, 2'b00, conv_r.ctype};
      end
      gtf_pkg::ADDR_PIN_SEQ_START: begin
        rdata_nxt = {1'b0, seq_r.addr};
      end
      gtf_pkg::ADDR_FILTER_CONFIG: begin
        rdata_nxt = {1'b0, filt_r.rsv6, filt_r.ftype, filt_r.rate};
      end
      default: begin
        rdata_nxt = gtf_pkg::READ_UNMAPPED;
      end
    endcase
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger input path
  // ----------------------------------------------------------------

  gtf_edge_sync u_edge (
    .clk(CLK),
    .rst(RST),
    .pin_in(PIN_I),
    .rise(pin_rise)
  );

  assign trig_en = (gpio_r.dir == gtf_pkg::DIR_INPUT) &&
                   ((gpio_r.isel == gtf_pkg::ISEL_CONV_START) || (gpio_r.isel == gtf_pkg::ISEL_SEQ_START));
  assign trig_seq = (gpio_r.isel == gtf_pkg::ISEL_SEQ_START);
  assign awake = (POWER_STATE == gtf_pkg::PWR_NORMAL);

  // Edges arriving while a start is pending are absorbed
  // wake before start
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      gtf_pkg::ST_IDLE: begin
        if (pin_rise && trig_en) begin
          state_nxt = awake ? gtf_pkg::ST_LAUNCH : gtf_pkg::ST_WAKE;
        end
      end
      gtf_pkg::ST_WAKE: begin
        if (awake) begin
          state_nxt = gtf_pkg::ST_LAUNCH;
        end
      end
      gtf_pkg::ST_LAUNCH: begin
        state_nxt = gtf_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = gtf_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= gtf_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Kind of start is latched at the edge, immune to later writes
  always_ff @(posedge CLK) begin
    if (RST) begin
      pend_seq_r <= 1'b0;
    end else if (state_r == gtf_pkg::ST_IDLE && pin_rise && trig_en) begin
      pend_seq_r <= trig_seq;
    end
  end

  // Wake request held until the power controller reports normal
  // request normal power
  always_ff @(posedge CLK) begin
    if (RST) begin
      WAKE_REQ <= 1'b0;
    end else begin
      WAKE_REQ <= (state_nxt == gtf_pkg::ST_WAKE);
    end
  end

  assign fire = (state_r == gtf_pkg::ST_LAUNCH);
  assign fire_seq = fire && pend_seq_r;

  // ----------------------------------------------------------------
  // Start requests toward converter and sequencer
  // ----------------------------------------------------------------

  // Setup is sampled at launch and held with the pulse's data
  // destination with request
  always_ff @(posedge CLK) begin
    if (RST) begin
      CONV_START <= 1'b0;
      CONV_REQ <= '0;
    end else begin
      CONV_START <= fire && !pend_seq_r;
      if (fire && !pend_seq_r) begin
        CONV_REQ.ctype <= conv_r.ctype;
        CONV_REQ.dest <= conv_r.dest;
      end
    end
  end

  // Pointer register writes alone never start a sequence; seq_r.addr is sampled at launch
  // pin event starts sequence
  always_ff @(posedge CLK) begin
    if (RST) begin
      SEQ_START <= 1'b0;
      SEQ_ADDR <= gtf_pkg::SEQ_ADDR_MIN;
    end else begin
      SEQ_START <= fire_seq;
      if (fire_seq) begin
        SEQ_ADDR <= seq_r.addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin output path
  // ----------------------------------------------------------------

  gtf_pin_drive u_drive (
    .clk(CLK),
    .rst(RST),
    .cfg(gpio_r),
    .irq(INTERRUPT_ACTIVE_HIGH_LEVEL),
    .mod_active(MOD_ACTIVE),
    .lsw_close(LSW_CLOSE),
    .pin_o(PIN_O),
    .pin_oe(PIN_OE)
  );

endmodule : gtf_trigger_cfg
`default_nettype wire

// File: verif/gtf_trigger_cfg_sva.sv
// Checker: port-level properties of the trigger and filter configuration block
`timescale 1ns/100ps
`default_nettype none

module gtf_trigger_cfg_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [1:0] POWER_STATE,
  input wire logic WAKE_REQ,
  input wire logic CONV_START,
  input wire gtf_pkg::gtf_conv_req_t CONV_REQ,
  input wire logic SEQ_START,
  input wire logic [6:0] SEQ_ADDR,
  input wire gtf_pkg::gtf_filter_sel_t FILTER_SEL,
  input wire logic CAL_START,
  input wire gtf_pkg::gtf_filter_sel_t CAL_FILTER_SEL
);
  // ----------------------------------------------------------------
  // Single clock domain, reset disables every check
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  AST_WAKE_HOLD: assert property (WAKE_REQ && POWER_STATE != gtf_pkg::PWR_NORMAL |=> WAKE_REQ)
    else $error("wake request dropped early");
  AST_WAKE_DONE: assert property (WAKE_REQ && POWER_STATE == gtf_pkg::PWR_NORMAL |-> ##[1:2] !WAKE_REQ)
    else $error("wake request not released");
  AST_WAKE_LAUNCH: assert property ($fell(WAKE_REQ) |-> ##[0:3] (CONV_START || SEQ_START))
    else $error("no start after wake");
  AST_START_AWAKE: assert property (CONV_START || SEQ_START |-> !WAKE_REQ)
    else $error("start while still waking");
  AST_START_NORMAL: assert property (CONV_START || SEQ_START |-> $past(POWER_STATE, 2) == gtf_pkg::PWR_NORMAL)
    else $error("start issued before normal power");
  AST_CONV_PULSE: assert property (CONV_START |=> !CONV_START)
    else $error("conversion start not a pulse");
  AST_REQ_HOLD: assert property ($changed(CONV_REQ) |-> CONV_START)
    else $error("conversion setup moved without start");
  AST_SEQ_HOLD: assert property ($changed(SEQ_ADDR) |-> SEQ_START)
    else $error("sequence address moved without start");
  AST_SEQ_RANGE: assert property (SEQ_ADDR >= gtf_pkg::SEQ_ADDR_MIN && SEQ_ADDR <= gtf_pkg::SEQ_ADDR_MAX)
    else $error("sequence address out of window");
  AST_FILTER_COPY: assert property (REG_WR && REG_ADDR == gtf_pkg::ADDR_FILTER_CONFIG |=> ##1
    FILTER_SEL == $past(REG_WDATA[5:0], 2))
    else $error("filter selection not updated");
  AST_CAL_SNAP: assert property (CAL_START && !$past(REG_WR) |=> CAL_FILTER_SEL == $past(FILTER_SEL))
    else $error("calibration snapshot wrong");
endmodule : gtf_trigger_cfg_chk

bind gtf_trigger_cfg gtf_trigger_cfg_chk i_chk (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_WDATA(REG_WDATA), .POWER_STATE(POWER_STATE), .WAKE_REQ(WAKE_REQ), .CONV_START(CONV_START),
  .CONV_REQ(CONV_REQ), .SEQ_START(SEQ_START), .SEQ_ADDR(SEQ_ADDR), .FILTER_SEL(FILTER_SEL),
  .CAL_START(CAL_START), .CAL_FILTER_SEL(CAL_FILTER_SEL));

`default_nettype wire

// File: verif/gtf_trigger_src.sv
// Partner model: external trigger source and power controller facing the block
`timescale 1ns/100ps
`default_nettype none

module gtf_trigger_src (
  input wire logic clk,
  input wire logic wake_req,
  output logic pin_level,
  output logic [1:0] power_state
);
  int wake_delay = 0;
  int wait_cnt = 0;

  // Idle low, device powered up
  initial begin
    pin_level = 1'b0;
    power_state = gtf_pkg::PWR_NORMAL;
  end

  // both levels held two clocks or more
  task automatic pulse(input int hold);
    int h = (hold < 2) ? 2 : hold;
    @(posedge clk) pin_level <= 1'b1;
    repeat (h) @(posedge clk);
    pin_level <= 1'b0;
    repeat (h) @(posedge clk);
  endtask : pulse

  // Power state change (normal, standby or sleep); the delay sets how slowly a wake is honoured
  task automatic set_power(input logic [1:0] state, input int delay);
    @(posedge clk) power_state <= state;
    wake_delay = delay;
  endtask : set_power

  // Answer a wake request after the chosen delay
  always @(posedge clk) begin
    if (wake_req && power_state != gtf_pkg::PWR_NORMAL) begin
      if (wait_cnt >= wake_delay) begin
        power_state <= gtf_pkg::PWR_NORMAL;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule : gtf_trigger_src

`default_nettype wire

// File: verif/test_gtf_trigger_cfg.sv
// Testbench: registers, pin triggers, pin output and filter scenarios
`timescale 1ns/100ps
`default_nettype none

module test_gtf_trigger_cfg;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic interrupt_active_high_level = 1'b0;
  logic mod_active = 1'b0;
  logic lsw_close = 1'b0;
  logic cal_start = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid, pin_o, pin_oe, src_pin, wake_req, conv_start, seq_start;
  logic [1:0] power_state;
  logic [6:0] seq_addr;
  gtf_pkg::gtf_conv_req_t conv_req;
  gtf_pkg::gtf_filter_sel_t filter_sel, cal_filter_sel;
  logic [11:0] expq[$];
  int miscompares = 0;
  int n_tests = 0;
  // Shared pin: the device wins while it drives
  wire logic pin_wire = (pin_oe === 1'b1) ? pin_o : src_pin;

  gtf_trigger_cfg i_dut (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .PIN_I(pin_wire), .PIN_O(pin_o),
    .PIN_OE(pin_oe), .POWER_STATE(power_state), .WAKE_REQ(wake_req), .INTERRUPT_ACTIVE_HIGH_LEVEL(interrupt_active_high_level),
    .MOD_ACTIVE(mod_active), .LSW_CLOSE(lsw_close), .CONV_START(conv_start), .CONV_REQ(conv_req),
    .SEQ_START(seq_start), .SEQ_ADDR(seq_addr), .FILTER_SEL(filter_sel), .CAL_START(cal_start),
    .CAL_FILTER_SEL(cal_filter_sel));
  gtf_trigger_src i_src (.clk(clk), .wake_req(wake_req), .pin_level(src_pin), .power_state(power_state));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back({4'h1, e});
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 1'b0;
  endtask : rd

  task automatic cal;
    @(posedge clk) cal_start <= 1'b1;
    @(posedge clk) cal_start <= 1'b0;
    @(negedge clk);
  endtask : cal

  // Bounded wait for every noted result to show up
  task automatic drain;
    for (int i = 0; i < 80 && expq.size() != 0; i++) @(posedge clk);
    check(12'(expq.size()), 12'h000);
  endtask : drain

  function automatic logic [1:0] pin_exp(input logic [7:0] c, input logic irq, input logic md, input logic ls);
    logic lvl;
    case (c[2:0])
      3'h1: lvl = ~irq;
      3'h2: lvl = irq;
      3'h4: lvl = 1'b1;
      3'h6: lvl = md;
      default: lvl = 1'b0;
    endcase
    if (c[7:6] == 2'b00 || c[2:0] == 3'h0) return 2'b00;
    if (c[2:0] == 3'h5) return {ls, 1'b0};
    if (c[7:6] == 2'b11) return {1'b1, lvl};
    return {~lvl, 1'b0};
  endfunction : pin_exp

  // Result monitor: each read, conversion or sequence start takes the oldest note
  always @(negedge clk) begin
    if (!rst) begin
      if (reg_rvalid) check({4'h1, reg_rdata}, expq.size() ? expq.pop_front() : 12'hfff);
      if (conv_start) check({4'h2, 3'h0, conv_req}, expq.size() ? expq.pop_front() : 12'hfff);
      if (seq_start) check({4'h3, 1'b0, seq_addr}, expq.size() ? expq.pop_front() : 12'hfff);
    end
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end

  initial begin
    logic [7:0] v;
    logic [7:0] cur;
    logic [1:0] e;
    int rises;
    static logic [7:0] rst_tab[5] = '{8'h00, 8'h00, 8'h3a, 8'h00, 8'h00};
    static logic [15:0] gp_tab[4] = '{16'hc4c4, 16'h71c1, 16'hb686, 16'h5b93};
    static logic [15:0] sq_tab[6] = '{16'h6f6f, 16'h396f, 16'h706f, 16'h3a3a, 16'h7f3a, 16'h5555};
    void'($urandom(30295));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped write ignored
    wr(8'h09, 8'hff);
    foreach (rst_tab[i]) rd(8'h05 + 8'(i), rst_tab[i]);
    foreach (gp_tab[i]) begin
      wr(8'h05, gp_tab[i][15:8]);
      rd(8'h05, gp_tab[i][7:0]);
    end
    foreach (sq_tab[i]) begin
      wr(8'h07, sq_tab[i][15:8]);
      rd(8'h07, sq_tab[i][7:0]);
    end
    for (int f = 0; f < 4; f++) begin
      v = {2'b00, 2'(f), 4'($urandom)};
      wr(8'h08, v);
      rd(8'h08, v);
      cal();
      check({6'h00, cal_filter_sel}, {4'h0, v});
      check({6'h00, filter_sel}, {4'h0, v});
    end
    // A later filter write must leave the snapshot alone
    wr(8'h08, {2'b00, ~v[5:0]});
    repeat (3) @(negedge clk);
    check({6'h00, cal_filter_sel}, {4'h0, v});
    // Pin conversions: setup write alone must not start anything
    wr(8'h05, 8'h10);
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, 3'(i), 2'b00, 2'(i)};
      wr(8'h06, v);
      repeat (6) @(posedge clk);
      expq.push_back({4'h2, 3'h0, v[1:0], v[6:4]});
      i_src.pulse(2 + i % 2);
      drain();
    end
    // Pin sequences from normal, standby and sleep
    wr(8'h05, 8'h20);
    for (int p = 0; p < 3; p++) begin
      v = 8'h3a + 8'($urandom % 54);
      wr(8'h07, v);
      i_src.set_power(2'(p), 2 * p);
      expq.push_back({4'h3, v});
      i_src.pulse(2);
      drain();
    end
    // Pin drive for every direction and output codes 0 to 6; trigger edges in output mode are ignored
    cur = 8'h20;
    for (int d = 0; d < 4; d++) begin
      for (int o = 0; o < 7; o++) begin
        @(posedge clk) {interrupt_active_high_level, mod_active, lsw_close} <= 3'($urandom);
        if (d != 1) cur[7:6] = 2'(d);
        cur[5:0] = {2'b01, 1'b0, 3'(o)};
        wr(8'h05, {2'(d), cur[5:0]});
        repeat (2) @(posedge clk);
        @(negedge clk);
        e = pin_exp(cur, interrupt_active_high_level, mod_active, lsw_close);
        check({10'h000, pin_oe, pin_o & e[1]}, {10'h000, e});
      end
    end
    // Clock output: about 25 rising edges in 407 cycles
    wr(8'h05, 8'hc7);
    rises = 0;
    @(negedge clk) v[0] = pin_o;
    repeat (407) begin
      @(negedge clk);
      rises += int'(pin_o && !v[0]);
      v[0] = pin_o;
    end
    check(12'(rises >= 24 && rises <= 26), 12'h001);
    // Input disabled: an edge must not start anything
    wr(8'h05, 8'h00);
    repeat (10) @(posedge clk);
    i_src.pulse(2);
    repeat (10) @(posedge clk);
    drain();
    summarize();
  end
endmodule : test_gtf_trigger_cfg

`default_nettype wire
